// ==== include/input_port_params.svh ====
// constants for the four-bit input port with interrupt and debounce
// Operation
// - software reads live pin levels any time
// - mask, edge, debounce and pull inhibit chosen per bit
// - sleep cuts pulls/inputs unless monitor set
// - debounce select picks raw or debounced path
// - accept level stable over two debounce edges
// - debounce worst case 16, 2, 0.25 ms
// - per-pin edge select rising or falling
// - four pins request, each with mask
// - request flags show which pin interrupted
// - masks clear to zero after reset
// - only edges after unmasking are stored
// - edge reselect may raise an immediate request
// - pull only with one option, inhibit clear
// - pins 0 and 1 feed always-debounced tests
// - test one pin0, two pin1, three buffer empty
// - pins 0 and 3 clock the event counter
// - counter clock uses same debounce/edge bits
// - mask 0 blocks storing; edge 0 rising
// - write one clears a request flag
// - debounce clock: tap 256 or alternate tap
`ifndef INPUT_PORT_PARAMS_SVH
`define INPUT_PORT_PARAMS_SVH
`define PORT_WIDTH          4
`define OFS_PIN_LEVEL       8'h00
`define OFS_IRQ_MASK        8'h04
`define OFS_IRQ_REQUEST     8'h08
`define OFS_EDGE_SELECT     8'h0C
`define OFS_DEBOUNCE_SELECT 8'h10
`define OFS_PULL_INHIBIT    8'h14
`define OFS_DIVIDER_CONTROL 8'h18
`define OFS_SLEEP_CONTROL   8'h1C
`define RST_NIBBLE          4'h0
`define BIT_DEB_CLK_SEL     0
`define BIT_WAKE_MONITOR    0
`define BIT_SLEEP_MODE      1
`define DIV_WIDTH           15
`define TAP_256             7
`define TAP_32              4
`define TAP_4               1
`endif

// ==== include/input_port_pkg.sv ====
// types for the input port block
package input_port_pkg;
	typedef struct packed {
		logic [3:0] mask;
		logic [3:0] edge_sel;
		logic [3:0] deb_sel;
		logic [3:0] pull_inh;
	} port_cfg_s;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_e;
endpackage

// ==== rtl/pin_debounce.sv ====
// debouncer for one synchronised pin
`timescale 1ns/100ps
module pin_debounce (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic tick_i,
	input  wire logic level_i,
	output logic      level_o
);
	logic [1:0] stable;
	// =====================================================
	// two ticks of unchanged level before accepting
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stable  <= 2'h0;
			level_o <= 1'b0;
		end else if (level_i == level_o) begin
			stable <= 2'h0;
		end else if (tick_i) begin
			if (stable == 2'h1) begin
				level_o <= level_i;
				stable  <= 2'h0;
			end else begin
				stable <= 2'h1;
			end
		end
	end
endmodule

// ==== rtl/input_port_irq_debounce.sv ====
// four-bit input port with per-pin interrupt, debounce and pull control
`timescale 1ns/100ps
`include "input_port_params.svh"
module input_port_irq_debounce
	import input_port_pkg::*;
#(
	parameter bit [1:0] ALT_TAP_4   = 2'h0,
	parameter bit [3:0] PULLUP_FIT  = 4'h0,
	parameter bit [3:0] PULLDN_FIT  = 4'hF
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [3:0]  input_pins_i,
	input  wire logic        write_buffer_empty_i,
	input  wire logic [3:0]  reset_combination_i,
	output logic      [3:0]  pin_irq_request_o,
	output logic             irq_any_o,
	output logic      [3:0]  pullup_on_o,
	output logic      [3:0]  pulldown_on_o,
	output logic      [3:0]  input_buffer_on_o,
	output logic             sleep_wake_o,
	output logic             branch_test_one_o,
	output logic             branch_test_two_o,
	output logic             branch_test_three_o,
	output logic             counter_clk_pin0_o,
	output logic             counter_clk_pin3_o
);
	// =====================================================
	// state
	port_cfg_s              cfg;
	logic [3:0]             input_irq_request;
	logic                   deb_clk_sel;
	logic                   sleep_wake_monitor_enable;
	logic                   sleep_mode;
	bus_state_e             bus_state;
	logic [3:0]             sync1;
	logic [3:0]             sync2;
	logic [3:0]             deb_level;
	logic [3:0]             path_level;
	logic [3:0]             path_prev;
	logic [3:0]             irq_level;
	logic [3:0]             irq_prev;
	logic [3:0]             irq_edge;
	logic [`DIV_WIDTH-1:0]  divider;
	logic [`DIV_WIDTH-1:0]  divider_prev;
	logic                   deb_tap;
	logic                   deb_tap_prev;
	logic                   deb_tick;
	logic                   wb_req;
	logic                   wr_stb;
	logic                   rd_stb;
	logic [3:0]             wr_nib;
	logic [31:0]            next_rdata;
	logic [3:0]             next_request;
	logic [3:0]             clr_request;
	logic [3:0]             sel_post;

	assign wb_req = wb_cyc_i && wb_stb_i && (bus_state == BUS_IDLE);
	assign wr_stb = wb_req && wb_we_i && wb_sel_i[0];
	assign rd_stb = wb_req && !wb_we_i;
	assign wr_nib = wb_dat_i[3:0];

	// =====================================================
	// wishbone slave, one wait cycle then ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_state <= BUS_IDLE;
		end else begin
			case (bus_state)
				BUS_IDLE: begin
					if (wb_req) begin
						bus_state <= BUS_ACK;
					end
				end
				BUS_ACK: begin
					bus_state <= BUS_IDLE;
				end
				default: begin
					bus_state <= BUS_IDLE;
				end
			endcase
		end
	end
	assign wb_ack_o = (bus_state == BUS_ACK);

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (wb_adr_i)
			`OFS_PIN_LEVEL:       next_rdata[3:0] = input_pins_i;
			`OFS_IRQ_MASK:        next_rdata[3:0] = cfg.mask;
			`OFS_IRQ_REQUEST:     next_rdata[3:0] = input_irq_request;
			`OFS_EDGE_SELECT:     next_rdata[3:0] = cfg.edge_sel;
			`OFS_DEBOUNCE_SELECT: next_rdata[3:0] = cfg.deb_sel;
			`OFS_PULL_INHIBIT:    next_rdata[3:0] = cfg.pull_inh;
			`OFS_DIVIDER_CONTROL: next_rdata[`BIT_DEB_CLK_SEL] = deb_clk_sel;
			`OFS_SLEEP_CONTROL: begin
				next_rdata[`BIT_WAKE_MONITOR] = sleep_wake_monitor_enable;
				next_rdata[`BIT_SLEEP_MODE]   = sleep_mode;
			end
			default:              next_rdata = 32'h0000_0000;
		endcase
	end

	// unmapped addresses read zero and ignore writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd_stb) begin
			wb_dat_o <= next_rdata;
		end
	end

	// =====================================================
	// configuration registers, each bit per pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg.mask     <= `RST_NIBBLE;
			cfg.edge_sel <= `RST_NIBBLE;
			cfg.deb_sel  <= `RST_NIBBLE;
			cfg.pull_inh <= `RST_NIBBLE;
		end else if (wr_stb) begin
			case (wb_adr_i)
				`OFS_IRQ_MASK:        cfg.mask     <= wr_nib;
				`OFS_EDGE_SELECT:     cfg.edge_sel <= wr_nib;
				`OFS_DEBOUNCE_SELECT: cfg.deb_sel  <= wr_nib;
				`OFS_PULL_INHIBIT:    cfg.pull_inh <= wr_nib;
				default:              cfg.mask     <= cfg.mask;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			deb_clk_sel               <= 1'b0;
			sleep_wake_monitor_enable <= 1'b0;
			sleep_mode                <= 1'b0;
		end else if (wr_stb && wb_adr_i == `OFS_DIVIDER_CONTROL) begin
			deb_clk_sel <= wr_nib[`BIT_DEB_CLK_SEL];
		end else if (wr_stb && wb_adr_i == `OFS_SLEEP_CONTROL) begin
			sleep_wake_monitor_enable <= wr_nib[`BIT_WAKE_MONITOR];
			sleep_mode                <= wr_nib[`BIT_SLEEP_MODE];
		end else if (sleep_wake_o) begin
			sleep_mode <= 1'b0;
		end
	end

	// =====================================================
	// prescaler taps for the debounce clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			divider      <= 15'h0000;
			divider_prev <= 15'h0000;
			deb_tap_prev <= 1'b0;
		end else begin
			divider      <= divider + 15'h0001;
			divider_prev <= divider;
			deb_tap_prev <= deb_tap;
		end
	end

	// tap 256 gives 16 ms worst case at 32 kHz, 32 gives 2 ms, 4 gives 0.25 ms
	always_comb begin
		if (!deb_clk_sel) begin
			deb_tap = divider[`TAP_256];
		end else if (ALT_TAP_4 != 2'h0) begin
			deb_tap = divider[`TAP_4];
		end else begin
			deb_tap = divider[`TAP_32];
		end
	end
	assign deb_tick = deb_tap && !deb_tap_prev;

	// =====================================================
	// synchronisers and debouncers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end else begin
			sync1 <= input_pins_i;
			sync2 <= sync1;
		end
	end

	// one debouncer per pin shared by irq, test and counter paths
	genvar g;
	generate
		for (g = 0; g < `PORT_WIDTH; g++) begin : g_deb
			pin_debounce u_deb (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.tick_i  (deb_tick),
				.level_i (sync2[g]),
				.level_o (deb_level[g])
			);
		end
	endgenerate

	// edge 1 inverts, so a rising edge of irq_level is the active edge
	assign path_level = (cfg.deb_sel & sync2) | (~cfg.deb_sel & deb_level);
	assign irq_level  = path_level ^ cfg.edge_sel;

	// =====================================================
	// edge detection and request flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			path_prev <= 4'h0;
			irq_prev  <= 4'h0;
		end else begin
			path_prev <= path_level;
			irq_prev  <= irq_level;
		end
	end

	assign irq_edge    = irq_level & ~irq_prev;
	assign clr_request = (wr_stb && wb_adr_i == `OFS_IRQ_REQUEST) ? wr_nib : 4'h0;
	assign sel_post    = path_prev;

	// set beats clear; a masked pin stores nothing
	always_comb begin
		next_request = (input_irq_request & ~clr_request) | (irq_edge & cfg.mask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			input_irq_request <= `RST_NIBBLE;
		end else begin
			input_irq_request <= next_request;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_irq_request_o <= 4'h0;
		end else begin
			pin_irq_request_o <= irq_edge & cfg.mask;
		end
	end
	assign irq_any_o = |input_irq_request;

	// =====================================================
	// pulls, sleep and wake monitor
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pullup_on_o       <= 4'h0;
			pulldown_on_o     <= 4'h0;
			input_buffer_on_o <= 4'h0;
			sleep_wake_o      <= 1'b0;
		end else begin
			// both options fitted is illegal and yields no pull
			pullup_on_o   <= PULLUP_FIT & ~PULLDN_FIT & ~cfg.pull_inh
				& {4{!sleep_mode || sleep_wake_monitor_enable}};
			pulldown_on_o <= PULLDN_FIT & ~PULLUP_FIT & ~cfg.pull_inh
				& {4{!sleep_mode || sleep_wake_monitor_enable}};
			input_buffer_on_o <= {4{!sleep_mode || sleep_wake_monitor_enable}};
			// raw pins so wake does not wait for a debounce clock
			sleep_wake_o <= sleep_mode && sleep_wake_monitor_enable
				&& (reset_combination_i != 4'h0)
				&& ((sync2 & reset_combination_i) == reset_combination_i);
		end
	end

	// =====================================================
	// branch tests and counter clocks
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			branch_test_one_o   <= 1'b0;
			branch_test_two_o   <= 1'b0;
			branch_test_three_o <= 1'b0;
			counter_clk_pin0_o  <= 1'b0;
			counter_clk_pin3_o  <= 1'b0;
		end else begin
			branch_test_one_o   <= deb_level[0];
			branch_test_two_o   <= deb_level[1];
			branch_test_three_o <= write_buffer_empty_i;
			// debounced path is safer for counting, software picks it
			counter_clk_pin0_o  <= irq_level[0];
			counter_clk_pin3_o  <= irq_level[3];
		end
	end
endmodule

// ==== testbench/pin_switches.sv ====
// switch model driving the four input pins, with optional contact chatter
`timescale 1ns/100ps
module pin_switches (
	input  wire logic       clk_i,
	input  wire logic [3:0] level_i,
	input  wire logic       bounce_i,
	output logic      [3:0] pins_o
);
	logic [3:0] prev = 4'h0;
	logic [3:0] left = 4'h0;
	initial pins_o = 4'h0;
	// ==========================================
	// chatter: level inverted on alternate cycles, four of the eight cycles after each change
	// plain always: the initial values above would give always_ff a second driver
	always @(posedge clk_i) begin
		prev <= level_i;
		if (level_i != prev) left <= 4'h8;
		else if (left != 4'h0) left <= left - 4'h1;
		pins_o <= (bounce_i && left[0]) ? ~level_i : level_i;
	end
endmodule

// ==== testbench/input_port_irq_debounce_monitor.sv ====
// concurrent checks on the input port block's ports
`timescale 1ns/100ps
module input_port_irq_debounce_monitor (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        write_buffer_empty_i,
	input wire logic        branch_test_three_o,
	input wire logic [3:0]  pin_irq_request_o,
	input wire logic        irq_any_o,
	input wire logic [3:0]  pullup_on_o,
	input wire logic [3:0]  pulldown_on_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================
	// bus, request, pull and test checks
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	a_data_holds: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i) |=> $stable(wb_dat_o))
		else $error("read data changed without a read");
	a_pulse_single: assert property ((pin_irq_request_o & $past(pin_irq_request_o)) == 4'h0)
		else $error("request pulse longer than one cycle");
	a_flag_follows: assert property (|pin_irq_request_o |-> ##[0:2] irq_any_o)
		else $error("request pulse not reflected in flags");
	a_release_clean: assert property ($fell(rst_i) |-> !irq_any_o && pin_irq_request_o == 4'h0)
		else $error("flags set right after reset");
	a_pull_exclusive: assert property ((pullup_on_o & pulldown_on_o) == 4'h0 && pullup_on_o == 4'h0)
		else $error("pull-up active or both pulls on");
	a_test_three: assert property (branch_test_three_o == $past(write_buffer_empty_i))
		else $error("buffer empty test not following input");
	c_write: cover property (wb_ack_o && wb_we_i);
	c_request: cover property (|pin_irq_request_o);
	c_pulldown: cover property ($fell(pulldown_on_o[0]));
endmodule

// ==== testbench/input_port_irq_debounce_bench.sv ====
// self-checking bench for the input port block
`timescale 1ns/100ps
`include "input_port_params.svh"
module input_port_irq_debounce_bench
	import input_port_pkg::*;
;
	logic clk_i, rst_i, cyc, stb, we, wbe, bounce, ack, t1, t2, t3, c0, c3, wake, any;
	logic [7:0]  adr;
	logic [31:0] dat, rdat;
	logic [3:0]  level, pins, rc, req, pu, pd, ib;
	int n_mismatch = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	pin_switches u_pin_switches (.clk_i(clk_i), .level_i(level), .bounce_i(bounce), .pins_o(pins));
	input_port_irq_debounce u_input_port_irq_debounce (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.input_pins_i(pins), .write_buffer_empty_i(wbe), .reset_combination_i(rc), .pin_irq_request_o(req),
		.irq_any_o(any), .pullup_on_o(pu), .pulldown_on_o(pd), .input_buffer_on_o(ib), .sleep_wake_o(wake),
		.branch_test_one_o(t1), .branch_test_two_o(t2), .branch_test_three_o(t3),
		.counter_clk_pin0_o(c0), .counter_clk_pin3_o(c3));
	// ==========================================
	// access tasks
	task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] d, output logic [3:0] q);
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, 28'h0, d};
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		q = rdat[3:0];
		{cyc, stb} <= 2'b00;
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] d);
		logic [3:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [3:0] e, input string nm);
		logic [3:0] q;
		wb(1'b0, a, 4'h0, q);
		chk(nm, e, q);
	endtask
	task automatic settle(input logic v);
		n = 0;
		while (t1 !== v && n < 1000) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			results();
		end
	end
	// ==========================================
	// scenarios
	initial begin
		{rst_i, cyc, stb, we, adr, dat, wbe, bounce, level, rc} = {1'b1, 53'h0};
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`OFS_IRQ_MASK, 4'h0, "mask reset");
		rd(`OFS_IRQ_REQUEST, 4'h0, "request reset");
		level <= 4'hA;
		rd(8'h40, 4'h0, "unmapped");
		rd(`OFS_PIN_LEVEL, 4'hA, "pin level");
		wr(`OFS_DEBOUNCE_SELECT, 4'hF);
		wr(`OFS_IRQ_MASK, 4'h5);
		level <= 4'hF;
		repeat (6) @(posedge clk_i);
		rd(`OFS_IRQ_REQUEST, 4'h5, "raw rising");
		chk("irq any", 4'h1, {3'b000, any});
		wr(`OFS_IRQ_REQUEST, 4'h1);
		wr(`OFS_IRQ_REQUEST, 4'h0);
		rd(`OFS_IRQ_REQUEST, 4'h4, "w1c");
		wr(`OFS_IRQ_MASK, 4'h0);
		level <= 4'h0;
		wr(`OFS_IRQ_REQUEST, 4'hF);
		level <= 4'hF;
		repeat (6) @(posedge clk_i);
		wr(`OFS_IRQ_MASK, 4'hF);
		level <= 4'h0;
		rd(`OFS_IRQ_REQUEST, 4'h0, "masked edges");
		wr(`OFS_EDGE_SELECT, 4'h2);
		rd(`OFS_IRQ_REQUEST, 4'h2, "edge reselect");
		wr(`OFS_IRQ_MASK, 4'h0);
		wr(`OFS_EDGE_SELECT, 4'h9);
		repeat (2) @(posedge clk_i);
		chk("counter clk", 4'h3, {2'b00, c3, c0});
		wr(`OFS_EDGE_SELECT, 4'h0);
		wr(`OFS_DEBOUNCE_SELECT, 4'h0);
		wr(`OFS_DIVIDER_CONTROL, 4'h1);
		wr(`OFS_IRQ_REQUEST, 4'hF);
		wr(`OFS_IRQ_MASK, 4'hF);
		bounce <= 1'b1;
		level <= 4'h3;
		settle(1'b1);
		chk("fast tap low", 4'h1, 4'(n >= 30));
		chk("fast tap high", 4'h1, 4'(n <= 90));
		chk("tests", 4'h3, {2'b00, t2, t1});
		rd(`OFS_IRQ_REQUEST, 4'h3, "debounced once");
		wr(`OFS_DIVIDER_CONTROL, 4'h0);
		level <= 4'h0;
		settle(1'b0);
		chk("slow tap", 4'h1, 4'(n >= 240 && n <= 540));
		chk("pull default", 4'hF, pd);
		chk("no pull-up", 4'h0, pu);
		wr(`OFS_PULL_INHIBIT, 4'h5);
		repeat (2) @(posedge clk_i);
		chk("pull inhibit", 4'hA, pd);
		wbe <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk("test three", 4'h1, {3'b000, t3});
		wr(`OFS_SLEEP_CONTROL, 4'h2);
		repeat (2) @(posedge clk_i);
		chk("sleep pulls", 4'h0, pd | ib);
		wr(`OFS_SLEEP_CONTROL, 4'h3);
		repeat (2) @(posedge clk_i);
		chk("monitor pulls", 4'hA, pd);
		rc <= 4'h8;
		level <= 4'h8;
		n = 0;
		repeat (10) begin
			@(posedge clk_i);
			if (wake === 1'b1) n = 1;
		end
		chk("wake", 4'h1, 4'(n));
		rd(`OFS_SLEEP_CONTROL, 4'h1, "sleep cleared on wake");
		results();
	end
endmodule
bind input_port_irq_debounce input_port_irq_debounce_monitor u_input_port_irq_debounce_monitor (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .write_buffer_empty_i(write_buffer_empty_i),
	.branch_test_three_o(branch_test_three_o),
	.pin_irq_request_o(pin_irq_request_o), .irq_any_o(irq_any_o), .pullup_on_o(pullup_on_o),
	.pulldown_on_o(pulldown_on_o));
